// >>> common/timer_status_pkg.sv
package timer_status_pkg;

  // ****************************************************
  // bus geometry
  // ****************************************************
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int FLAG_COUNT = 8;

  // ****************************************************
  // register byte offsets
  // ****************************************************
  localparam logic [ADDR_W-1:0] EVENT_FLAGS_OFS = 6'h20;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_SET_OFS = 6'h24;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_CLEAR_OFS = 6'h28;
  localparam logic [ADDR_W-1:0] IRQ_MASK_VIEW_OFS = 6'h2c;

  // ****************************************************
  // field positions in the event flag register
  // ****************************************************
  localparam int OVERFLOW_BIT = 0;
  localparam int LOAD_OVERRUN_BIT = 1;
  localparam int COMPARE_A_BIT = 2;
  localparam int COMPARE_B_BIT = 3;
  localparam int COMPARE_C_BIT = 4;
  localparam int LOAD_A_BIT = 5;
  localparam int LOAD_B_BIT = 6;
  localparam int EXT_TRIGGER_BIT = 7;
  localparam int CLOCK_ON_BIT = 16;
  localparam int LINE_A_MIRROR_BIT = 17;
  localparam int LINE_B_MIRROR_BIT = 18;

  // ****************************************************
  // mode gating and reset values
  // ****************************************************
  localparam logic [FLAG_COUNT-1:0] CAPTURE_ONLY_FLAGS = 8'h62;
  localparam logic [FLAG_COUNT-1:0] WAVE_ONLY_FLAGS = 8'h0c;
  localparam logic [FLAG_COUNT-1:0] FLAGS_RESET = 8'h00;
  localparam logic [FLAG_COUNT-1:0] MASK_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_RESET = 32'h00000000;

endpackage

// >>> core/timer_channel_status_irq.sv
// Local design decision: the Avalon-MM slave port.
module timer_channel_status_irq (
  input wire logic clk,
  input wire logic rst,
  input wire logic [timer_status_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [timer_status_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [timer_status_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic waveMode,
  input wire logic overflowEvent,
  input wire logic compareAEvent,
  input wire logic compareBEvent,
  input wire logic compareCEvent,
  input wire logic loadAEvent,
  input wire logic loadBEvent,
  input wire logic captureAReadEvent,
  input wire logic captureBReadEvent,
  input wire logic extTriggerEvent,
  input wire logic counterClockOn,
  input wire logic channelIoAPin,
  input wire logic channelIoBPin,
  input wire logic channelIoADrive,
  input wire logic channelIoBDrive,
  output logic irqOut
);
  import timer_status_pkg::*;

  function automatic logic hitOffset(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] ofs);
    hitOffset = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // ****************************************************
  // bus slave: one wait cycle, then the answer
  // ****************************************************
  logic ack;
  logic [FLAG_COUNT-1:0] flags;
  logic [FLAG_COUNT-1:0] mask;
  logic pendA;
  logic pendB;
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic pinA;
  logic pinB;

  wire request = read | write;
  wire first = request & ~ack;
  wire hitStatus = hitOffset(address, EVENT_FLAGS_OFS);
  wire hitSet = hitOffset(address, IRQ_ENABLE_SET_OFS);
  wire hitClear = hitOffset(address, IRQ_ENABLE_CLEAR_OFS);
  wire hitMask = hitOffset(address, IRQ_MASK_VIEW_OFS);
  wire laneLow = byteenable[0];
  wire statusRead = first & read & hitStatus;
  wire setWrite = first & write & hitSet & laneLow;
  wire clearWrite = first & write & hitClear & laneLow;

  assign waitrequest = request & ~ack;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= first;
    end
  end

  // ****************************************************
  // pin synchronisers: a change counts once stages agree
  // ****************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA <= 3'h0;
      syncB <= 3'h0;
      pinA <= 1'b0;
      pinB <= 1'b0;
    end else begin
      syncA <= {syncA[1:0], channelIoAPin};
      syncB <= {syncB[1:0], channelIoBPin};
      if (syncA[1] == syncA[2]) begin
        pinA <= syncA[2];
      end
      if (syncB[1] == syncB[2]) begin
        pinB <= syncB[2];
      end
    end
  end

  // in waveform mode the pin is an output, so show what we drive
  // line a and line b mirrors
  wire lineAMirror = waveMode ? channelIoADrive : pinA;
  wire lineBMirror = waveMode ? channelIoBDrive : pinB;

  // ****************************************************
  // event flags
  // ****************************************************
  // a capture register counts as unread from its load until its read;
  // a read in the load cycle is taken as coming before the load
  // overrun detection
  wire overrunA = loadAEvent & pendA & ~captureAReadEvent;
  wire overrunB = loadBEvent & pendB & ~captureBReadEvent;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pendA <= 1'b0;
      pendB <= 1'b0;
    end else begin
      pendA <= loadAEvent | (pendA & ~captureAReadEvent);
      pendB <= loadBEvent | (pendB & ~captureBReadEvent);
    end
  end

  wire [FLAG_COUNT-1:0] rawEvents = {
    extTriggerEvent,
    loadBEvent,
    loadAEvent,
    compareCEvent,
    compareBEvent,
    compareAEvent,
    overrunA | overrunB,
    overflowEvent
  };

  wire [FLAG_COUNT-1:0] allowed =
    waveMode ? ~CAPTURE_ONLY_FLAGS : ~WAVE_ONLY_FLAGS;
  wire [FLAG_COUNT-1:0] events = rawEvents & allowed;

  // flags of the idle mode are forced low, even if set before a switch
  // set wins over read clear
  wire [FLAG_COUNT-1:0] next_flags =
    (events | (flags & {FLAG_COUNT{~statusRead}})) & allowed;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // ****************************************************
  // interrupt mask
  // ****************************************************
  // set and clear mask
  wire [FLAG_COUNT-1:0] next_mask =
    (mask | (writedata[FLAG_COUNT-1:0] & {FLAG_COUNT{setWrite}}))
    & ~(writedata[FLAG_COUNT-1:0] & {FLAG_COUNT{clearWrite}});

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask <= MASK_RESET;
    end else begin
      mask <= next_mask;
    end
  end

  assign irqOut = |(flags & mask);

  // ****************************************************
  // read data
  // ****************************************************
  // status layout
  wire [DATA_W-1:0] statusWord = (DATA_W'(flags))
    | (DATA_W'(counterClockOn) << CLOCK_ON_BIT)
    | (DATA_W'(lineAMirror) << LINE_A_MIRROR_BIT)
    | (DATA_W'(lineBMirror) << LINE_B_MIRROR_BIT);
  wire [DATA_W-1:0] maskWord = DATA_W'(mask);
  // write-only and unmapped offsets read as zero
  wire [DATA_W-1:0] readSelect =
    hitStatus ? statusWord : (hitMask ? maskWord : READ_RESET);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= READ_RESET;
    end else if (first & read) begin
      readdata <= readSelect;
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seqStatusRead;
    read && hitStatus && waitrequest;
  endsequence

  sequence seqStatusAnswer;
    read && hitStatus && !waitrequest;
  endsequence

  property pAnswerNext;
    request && waitrequest |=> !waitrequest;
  endproperty

  answer_timing_a: assert property (pAnswerNext)
    else $error("no answer one cycle after request");

  overflow_flag_a: assert property (
    overflowEvent |=> flags[OVERFLOW_BIT] [*1] ##0 irqOut == |(flags & mask))
    else $error("overflow did not set its flag");

  read_clear_a: assert property (
    seqStatusRead ##0 (rawEvents == 8'h00) |=> flags == 8'h00)
    else $error("status read did not clear flags");

  overrun_flag_a: assert property (
    !waveMode && loadAEvent ##1 !captureAReadEvent [*2] ##0 loadAEvent
    && !waveMode |=> flags[LOAD_OVERRUN_BIT])
    else $error("second load without read missed overrun");

  overrun_wave_a: assert property (
    waveMode |=> !flags[LOAD_OVERRUN_BIT])
    else $error("overrun flag set in waveform mode");

  compare_a_a: assert property (
    waveMode && compareAEvent ##1 !statusRead && waveMode
    |=> flags[COMPARE_A_BIT])
    else $error("compare a flag lost in waveform mode");

  compare_a_cap_a: assert property (
    !waveMode |=> !flags[COMPARE_A_BIT])
    else $error("compare a flag set in capture mode");

  compare_b_a: assert property (
    !waveMode ##1 flags[COMPARE_B_BIT] |-> $past(waveMode, 1) == 1'b1)
    else $error("compare b flag set in capture mode");

  compare_c_a: assert property (
    compareCEvent |=> flags[COMPARE_C_BIT])
    else $error("compare c flag not set");

  load_a_a: assert property (
    !waveMode && loadAEvent |=> flags[LOAD_A_BIT])
    else $error("load a flag not set in capture mode");

  load_b_a: assert property (
    waveMode |=> !flags[LOAD_B_BIT] && !flags[LOAD_A_BIT])
    else $error("load flag set in waveform mode");

  ext_trigger_a: assert property (
    extTriggerEvent |=> flags[EXT_TRIGGER_BIT])
    else $error("external trigger flag not set");

  clock_status_a: assert property (
    seqStatusRead |=> readdata[CLOCK_ON_BIT] == $past(counterClockOn))
    else $error("clock status bit wrong");

  mirror_a_a: assert property (
    seqStatusRead ##0 waveMode
    |=> readdata[LINE_A_MIRROR_BIT] == $past(channelIoADrive))
    else $error("line a mirror wrong in waveform mode");

  mirror_b_a: assert property (
    seqStatusRead ##0 !waveMode
    |=> readdata[LINE_B_MIRROR_BIT] == $past(pinB))
    else $error("line b mirror wrong in capture mode");

  mask_set_a: assert property (
    write && hitSet && laneLow && waitrequest
    |=> (mask & $past(writedata[7:0])) == $past(writedata[7:0])
    && (mask & ~$past(writedata[7:0])) == ($past(mask) & ~$past(writedata[7:0])))
    else $error("mask set write wrong");

  mask_clear_a: assert property (
    write && hitClear && laneLow && waitrequest
    |=> (mask & $past(writedata[7:0])) == 8'h00)
    else $error("mask clear write wrong");

  mask_view_a: assert property (
    read && hitMask && waitrequest
    |=> readdata == {24'h000000, $past(mask)})
    else $error("mask view read wrong");

  status_layout_a: assert property (
    seqStatusRead |=> readdata[31:19] == 13'h0
    && readdata[15:8] == 8'h00 && readdata[7:0] == $past(flags))
    else $error("status word layout wrong");

  irq_off_a: assert property (
    write && hitClear && laneLow && waitrequest && writedata[7:0] == 8'hff
    |=> !irqOut)
    else $error("interrupt stays high with all masks clear");

  set_wins_a: assert property (
    seqStatusRead ##0 extTriggerEvent |=> flags[EXT_TRIGGER_BIT])
    else $error("event lost in status read cycle");

endmodule

// >>> testbench/timer_channel_status_irq_test.sv
module timer_channel_status_irq_test;
  timeunit 1ns;
  timeprecision 1ns;
  import timer_status_pkg::*;

  // ****************************************************
  // stimulus and observed signals
  // ****************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [3:0] byteenable = 4'hf;
  logic [DATA_W-1:0] readdata;
  logic waitrequest;
  logic irqOut;
  logic waveMode = 1'b0;
  logic clockOn = 1'b0;
  // event bits sit at the same positions as their flags
  logic [7:0] ev = '0;
  logic [1:0] capRd = '0;
  logic pinA = 1'b0;
  logic pinB = 1'b0;
  logic driveA = 1'b0;
  logic driveB = 1'b0;
  logic [DATA_W-1:0] rd;
  int errorCnt = 0;
  int checkCount = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  timer_channel_status_irq dut (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .waveMode(waveMode),
    .overflowEvent(ev[0]), .compareAEvent(ev[2]), .compareBEvent(ev[3]),
    .compareCEvent(ev[4]), .loadAEvent(ev[5]), .loadBEvent(ev[6]),
    .captureAReadEvent(capRd[0]), .captureBReadEvent(capRd[1]),
    .extTriggerEvent(ev[7]), .counterClockOn(clockOn),
    .channelIoAPin(pinA), .channelIoBPin(pinB),
    .channelIoADrive(driveA), .channelIoBDrive(driveB), .irqOut(irqOut)
  );

  // ****************************************************
  // bus and compare tasks
  // ****************************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // evs lets an event pulse coincide with the first cycle of a request
  task automatic access(input logic wr, input logic [5:0] a,
                        input logic [31:0] d, input logic [7:0] evs);
    @(posedge clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    ev <= evs;
    do begin
      @(posedge clk);
      ev <= '0;
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic expectRead(input logic [5:0] a, input logic [31:0] exp,
                            input string name);
    access(1'b0, a, '0, '0);
    check(name, rd, exp);
  endtask

  task automatic pulse(input logic [7:0] m, input logic [1:0] r);
    @(posedge clk);
    ev <= m;
    capRd <= r;
    @(posedge clk);
    ev <= '0;
    capRd <= '0;
  endtask

  // a hang ends the run here rather than in the sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errorCnt++;
      conclude();
    end
  end

  // ****************************************************
  // test sequence
  // ****************************************************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    expectRead(IRQ_MASK_VIEW_OFS, 32'h0, "mask reset");
    expectRead(EVENT_FLAGS_OFS, 32'h0, "flags reset");
    $display("test reset done");
    access(1'b1, IRQ_ENABLE_SET_OFS, 32'hffffff81, '0);
    expectRead(IRQ_MASK_VIEW_OFS, 32'h81, "mask set");
    access(1'b1, IRQ_ENABLE_SET_OFS, 32'h24, '0);
    expectRead(IRQ_MASK_VIEW_OFS, 32'ha5, "mask set or");
    access(1'b1, IRQ_ENABLE_CLEAR_OFS, 32'h05, '0);
    expectRead(IRQ_MASK_VIEW_OFS, 32'ha0, "mask clear");
    access(1'b1, IRQ_MASK_VIEW_OFS, 32'hff, '0);
    byteenable <= 4'he;
    access(1'b1, IRQ_ENABLE_SET_OFS, 32'h0f, '0);
    byteenable <= 4'hf;
    expectRead(IRQ_MASK_VIEW_OFS, 32'ha0, "mask ignored");
    expectRead(IRQ_ENABLE_SET_OFS, 32'h0, "write only");
    expectRead(6'h30, 32'h0, "unmapped");
    access(1'b1, IRQ_ENABLE_CLEAR_OFS, 32'hff, '0);
    $display("test mask done");
    pulse(8'hdd, 2'b00);
    pulse(8'h20, 2'b00);
    pulse(8'h00, 2'b01);
    pulse(8'h20, 2'b00);
    expectRead(EVENT_FLAGS_OFS, 32'hf1, "capture flags");
    expectRead(EVENT_FLAGS_OFS, 32'h0, "read clears");
    pulse(8'h60, 2'b00);
    pulse(8'h60, 2'b00);
    expectRead(EVENT_FLAGS_OFS, 32'h62, "overrun");
    pulse(8'h00, 2'b11);
    pulse(8'h60, 2'b00);
    expectRead(EVENT_FLAGS_OFS, 32'h60, "no overrun");
    $display("test capture done");
    waveMode <= 1'b1;
    clockOn <= 1'b1;
    driveA <= 1'b1;
    pinB <= 1'b1;
    pulse(8'hff, 2'b00);
    pulse(8'hff, 2'b00);
    expectRead(EVENT_FLAGS_OFS, 32'h3009d, "wave flags");
    expectRead(EVENT_FLAGS_OFS, 32'h30000, "wave levels");
    waveMode <= 1'b0;
    expectRead(EVENT_FLAGS_OFS, 32'h50000, "pin levels");
    $display("test wave done");
    access(1'b1, IRQ_ENABLE_SET_OFS, 32'h80, '0);
    pulse(8'h80, 2'b00);
    @(posedge clk);
    check("irq on", {31'h0, irqOut}, 32'h1);
    access(1'b1, IRQ_ENABLE_CLEAR_OFS, 32'h80, '0);
    check("irq masked", {31'h0, irqOut}, 32'h0);
    access(1'b1, IRQ_ENABLE_SET_OFS, 32'h01, '0);
    check("irq other", {31'h0, irqOut}, 32'h0);
    access(1'b0, EVENT_FLAGS_OFS, '0, 8'h81);
    check("read with event", rd, 32'h50080);
    check("irq kept", {31'h0, irqOut}, 32'h1);
    expectRead(EVENT_FLAGS_OFS, 32'h50081, "event kept");
    $display("test irq done");
    conclude();
  end
endmodule
